//--- rtl/cidec_defs.svh
`ifndef CIDEC_DEFS_SVH
`define CIDEC_DEFS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define CIDEC_A_INSTR 12'h000
`define CIDEC_A_WORK 12'h004
`define CIDEC_A_STATUS 12'h008
`define CIDEC_A_PTR0 12'h00c
`define CIDEC_A_PTR1 12'h010
`define CIDEC_A_PC 12'h014
`define CIDEC_A_OPTION 12'h018
`define CIDEC_A_STACK 12'h01c
`define CIDEC_A_DIR_PAGE 7'h01
`define CIDEC_A_MEM_PAGE 3'h1
// ****************************************
// status field positions
// ****************************************
`define CIDEC_ST_C 0
`define CIDEC_ST_DCY 1
`define CIDEC_ST_Z 2
`define CIDEC_ST_PWRDN 3
`define CIDEC_ST_TIMEOUT 4
`define CIDEC_ST_GIE 5
`define CIDEC_ST_ILL 6
`define CIDEC_ST_STBY 7
`define CIDEC_ST_BUSY 8
`define CIDEC_ST_CYC 9
// ****************************************
// reset values and cycle counts
// ****************************************
`define CIDEC_OPTION_RST 8'hff
`define CIDEC_DIR_RST 8'hff
`define CIDEC_CYC_ONE 2'h1
`define CIDEC_CYC_TWO 2'h2
// ****************************************
// opcode patterns
// ****************************************
`define CIDEC_OP_NO_OPERATION 14'b00_0000_0000_0000
`define CIDEC_OP_RESET 14'b00_0000_0000_0001
`define CIDEC_OP_RETURN 14'b00_0000_0000_1000
`define CIDEC_OP_INTERRUPT_RETURN 14'b00_0000_0000_1001
`define CIDEC_OP_CALL_BY_WORKING 14'b00_0000_0000_1010
`define CIDEC_OP_BRANCH_BY_WORKING 14'b00_0000_0000_1011
`define CIDEC_OP_OPTION 14'b00_0000_0110_0010
`define CIDEC_OP_SLEEP 14'b00_0000_0110_0011
`define CIDEC_OP_WDT 14'b00_0000_0110_0100
`define CIDEC_OP_PORT_DIRECTION_LOAD 14'b00_0000_0110_0???
`define CIDEC_OP_LDMM 14'b00_0000_0001_0???
`define CIDEC_OP_STMM 14'b00_0000_0001_1???
`define CIDEC_OP_AND_WORKING_FILE 14'b00_0101_????_????
`define CIDEC_OP_ADD_WORKING_FILE 14'b00_0111_????_????
`define CIDEC_OP_CALL 14'b10_0???_????_????
`define CIDEC_OP_ABSOLUTE_JUMP 14'b10_1???_????_????
`define CIDEC_OP_PADD 14'b11_0001_0???_????
`define CIDEC_OP_RELATIVE_JUMP 14'b11_001?_????_????
`define CIDEC_OP_RETURN_LOAD_LITERAL 14'b11_0100_????_????
`define CIDEC_OP_AND_LITERAL_WORKING 14'b11_1001_????_????
`define CIDEC_OP_ADD_LITERAL_WORKING 14'b11_1110_????_????
`define CIDEC_OP_LDK 14'b11_1111_0???_????
`define CIDEC_OP_STK 14'b11_1111_1???_????
`endif

//--- rtl/cidec_pkg.sv
package cidec_pkg;
	typedef enum logic [1:0] {CIDEC_IDLE, CIDEC_EXEC, CIDEC_NOPC, CIDEC_STALL} cidec_state_t;
endpackage : cidec_pkg

//--- rtl/cidec_alu.sv
`timescale 1ns/10ps
`default_nettype none
module cidec_alu (
	input wire logic [7:0] a, // working register
	input wire logic [7:0] b, // literal or file value
	input wire logic op_add, // 1 add, 0 and
	output logic [7:0] res, // result
	output logic carry, // carry out
	output logic dcarry, // carry out of bit 3
	output logic zero // result is zero
);
	logic [8:0] sum;
	logic [4:0] nib;
	always_comb begin
		sum = {1'b0, a} + {1'b0, b};
		nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		res = op_add ? sum[7:0] : (a & b);
		carry = sum[8];
		dcarry = nib[4];
		zero = (res == 8'h00);
	end
endmodule : cidec_alu
`default_nettype wire

//--- rtl/cidec_ptr.sv
`timescale 1ns/10ps
`default_nettype none
module cidec_ptr (
	input wire logic [15:0] ptr, // selected pointer pair
	input wire logic [1:0] mode, // modify mode field
	input wire logic [5:0] ofs, // signed offset
	output logic [15:0] ptr_ofs, // pointer plus offset
	output logic [15:0] ptr_mod, // pointer after modify
	output logic [15:0] acc_addr // address used by modify forms
);
	always_comb begin
		// sign-extend and wrap at 16 bits
		ptr_ofs = ptr + {{10{ofs[5]}}, ofs}; // RQ8 RQ9
		ptr_mod = mode[0] ? ptr - 16'h0001 : ptr + 16'h0001; // RQ9
		// pre forms use the modified value, post forms the old one
		acc_addr = mode[1] ? ptr : ptr_mod;
	end
endmodule : cidec_ptr
`default_nettype wire

//--- rtl/cidec_core.sv
// Summary of operation
// RQ1: working-register relative branch takes two cycles, flags untouched.
// RQ2: call by working register pushes return address, two cycles.
// RQ3: return with literal loads working register, two cycles.
// RQ4: standby entry in one cycle, updates timeout and power-down flags.
// RQ5: option load copies working register, one cycle, no flags.
// RQ6: port-direction load copies working register into selected register; selections 2 to 4 decode as option, standby and watchdog instead.
// RQ7: pointer add literal to selected pair, one cycle, no flags.
// RQ8: pointer add literal is signed six bits, sign-extended to sixteen.
// RQ9: pointer arithmetic wraps modulo sixteen bits.
// RQ10: indirect load with pre/post modify, updates zero flag.
// RQ11: indexed indirect load, pointer unchanged, updates zero flag.
// RQ12: indirect store with pre/post modify, no flags.
// RQ13: indexed indirect store, pointer unchanged, no flags.
// RQ14: program counter change takes two cycles, second is a no-operation; the reset instruction clears it in one cycle.
// RQ15: indirect access through pointer with top bit set stalls one cycle.
// RQ16: literal AND into working register, zero flag only.
// RQ17: literal add into working register, carry, digit carry, zero.
// RQ18: file AND, result to working or file by d, zero only.
// RQ19: file add, result by d, carry, digit carry, zero.
// RQ20: remaining control and inherent encodings decoded as listed.
// RQ21: plain inherent or literal instruction completes in one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "cidec_defs.svh"
module cidec_core import cidec_pkg::*; (
	input wire logic ref_clk, // clock
	input wire logic srst, // synchronous reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	output logic standby, // in standby state
	output logic watchdog_kick, // one-cycle watchdog clear
	output logic soft_reset, // one-cycle software reset
	output logic [7:0] option_cfg, // option register
	output logic [63:0] port_dir // eight port-direction registers
);
	typedef struct packed {
		cidec_state_t st;
		logic [13:0] ir;
		logic [14:0] pc;
		logic [15:0][14:0] stk;
		logic [3:0] sp;
		logic [7:0] w;
		logic c, dcy, z, timeout, pwrdn, gie, ill, stby;
		logic [1:0] cyc;
		logic [7:0] option;
		logic [7:0][7:0] dir;
		logic [1:0][15:0] pptr;
		logic [127:0][7:0] mem;
		logic wdt, rst;
		logic pready, pslverr;
		logic [31:0] prdata;
	} cidec_reg_t;

	cidec_reg_t s, n;
	logic jump, hi, ptr_n, ind, lit;
	logic [6:0] faddr;
	logic [15:0] ptr_ofs, ptr_mod, acc_addr;
	logic [7:0] alu_b, alu_res;
	logic alu_c, alu_dc, alu_z, setup, acc_wr;
	logic [31:0] rd;
	logic mapped, ro;

	// ****************************************
	// operand selection
	// ****************************************
	assign ptr_n = (s.ir[13:12] == 2'b11) ? s.ir[6] : ((s.ir[13:4] == 10'h001) ? s.ir[2] : s.ir[0]);
	// file address 0 and 1 are the indirect access ports
	assign ind = (s.ir[6:1] == 6'h00);
	assign faddr = ind ? s.pptr[s.ir[0]][6:0] : s.ir[6:0];
	assign lit = s.ir[13];
	assign alu_b = lit ? s.ir[7:0] : s.mem[faddr];

	cidec_ptr i_cidec_ptr (
		.ptr(s.pptr[ptr_n]),
		.mode(s.ir[1:0]),
		.ofs(s.ir[5:0]),
		.ptr_ofs(ptr_ofs),
		.ptr_mod(ptr_mod),
		.acc_addr(acc_addr)
	);

	cidec_alu i_cidec_alu (
		.a(s.w),
		.b(alu_b),
		.op_add(s.ir[9]),
		.res(alu_res),
		.carry(alu_c),
		.dcarry(alu_dc),
		.zero(alu_z)
	);

	// ****************************************
	// apb decode
	// ****************************************
	assign setup = psel & ~penable;
	assign acc_wr = psel & penable & s.pready & pwrite & ~s.pslverr;

	always_comb begin
		rd = 32'h0000_0000;
		mapped = (paddr[1:0] == 2'b00);
		ro = 1'b0;
		if (paddr[11:9] == `CIDEC_A_MEM_PAGE) begin
			rd[7:0] = s.mem[paddr[8:2]];
		end else if (paddr[11:5] == `CIDEC_A_DIR_PAGE) begin
			rd[7:0] = s.dir[paddr[4:2]];
		end else begin
			case (paddr)
				`CIDEC_A_INSTR: rd[13:0] = s.ir;
				`CIDEC_A_WORK: rd[7:0] = s.w;
				`CIDEC_A_STATUS: begin
					rd[`CIDEC_ST_C] = s.c;
					rd[`CIDEC_ST_DCY] = s.dcy;
					rd[`CIDEC_ST_Z] = s.z;
					rd[`CIDEC_ST_PWRDN] = s.pwrdn;
					rd[`CIDEC_ST_TIMEOUT] = s.timeout;
					rd[`CIDEC_ST_GIE] = s.gie;
					rd[`CIDEC_ST_ILL] = s.ill;
					rd[`CIDEC_ST_STBY] = s.stby;
					rd[`CIDEC_ST_BUSY] = (s.st != CIDEC_IDLE);
					rd[`CIDEC_ST_CYC +: 2] = s.cyc;
				end
				`CIDEC_A_PTR0: rd[15:0] = s.pptr[0];
				`CIDEC_A_PTR1: rd[15:0] = s.pptr[1];
				`CIDEC_A_PC: rd[14:0] = s.pc;
				`CIDEC_A_OPTION: rd[7:0] = s.option;
				`CIDEC_A_STACK: begin
					rd[18:0] = {s.sp, s.stk[s.sp - 4'h1]};
					ro = 1'b1;
				end
				default: mapped = 1'b0;
			endcase
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		n = s;
		n.wdt = 1'b0;
		n.rst = 1'b0;
		jump = 1'b0;
		hi = 1'b0;
		n.pready = setup;
		if (setup) begin
			n.prdata = mapped ? rd : 32'h0000_0000;
			// writes only while idle; no instruction while in standby
			n.pslverr = ~mapped | (pwrite & (ro | (s.st != CIDEC_IDLE) |
				((paddr == `CIDEC_A_INSTR) & s.stby)));
		end
		if (acc_wr) begin
			if (paddr[11:9] == `CIDEC_A_MEM_PAGE) begin
				n.mem[paddr[8:2]] = pwdata[7:0];
			end else if (paddr[11:5] == `CIDEC_A_DIR_PAGE) begin
				n.dir[paddr[4:2]] = pwdata[7:0];
			end else begin
				case (paddr)
					`CIDEC_A_INSTR: begin
						n.ir = pwdata[13:0];
						n.st = CIDEC_EXEC;
					end
					`CIDEC_A_WORK: n.w = pwdata[7:0];
					`CIDEC_A_STATUS: begin
						n.c = pwdata[`CIDEC_ST_C];
						n.dcy = pwdata[`CIDEC_ST_DCY];
						n.z = pwdata[`CIDEC_ST_Z];
						n.ill = pwdata[`CIDEC_ST_ILL];
						// standby can only be left, writing 0 wakes
						n.stby = s.stby & pwdata[`CIDEC_ST_STBY];
					end
					`CIDEC_A_PTR0: n.pptr[0] = pwdata[15:0];
					`CIDEC_A_PTR1: n.pptr[1] = pwdata[15:0];
					`CIDEC_A_PC: n.pc = pwdata[14:0];
					`CIDEC_A_OPTION: n.option = pwdata[7:0];
					default: n.st = s.st;
				endcase
			end
		end
		case (s.st)
			CIDEC_EXEC: begin
				n.pc = s.pc + 15'h0001;
				casez (s.ir)
					`CIDEC_OP_BRANCH_BY_WORKING: begin
						jump = 1'b1; // RQ1
						n.pc = s.pc + 15'h0001 + {7'h00, s.w}; // RQ1
					end
					`CIDEC_OP_CALL_BY_WORKING: begin
						jump = 1'b1; // RQ2
						n.stk[s.sp] = s.pc + 15'h0001; // RQ2
						n.sp = s.sp + 4'h1;
						n.pc = {s.pc[14:8], s.w}; // RQ2
					end
					`CIDEC_OP_CALL: begin
						jump = 1'b1; // RQ20
						n.stk[s.sp] = s.pc + 15'h0001;
						n.sp = s.sp + 4'h1;
						n.pc = {s.pc[14:11], s.ir[10:0]};
					end
					`CIDEC_OP_ABSOLUTE_JUMP: begin
						jump = 1'b1; // RQ20
						n.pc = {s.pc[14:11], s.ir[10:0]};
					end
					`CIDEC_OP_RELATIVE_JUMP: begin
						jump = 1'b1; // RQ20
						n.pc = s.pc + 15'h0001 + {{6{s.ir[8]}}, s.ir[8:0]};
					end
					`CIDEC_OP_INTERRUPT_RETURN, `CIDEC_OP_RETURN, `CIDEC_OP_RETURN_LOAD_LITERAL: begin
						jump = 1'b1; // RQ3 RQ20
						n.sp = s.sp - 4'h1;
						n.pc = s.stk[s.sp - 4'h1];
						if (s.ir[13]) begin
							n.w = s.ir[7:0]; // RQ3
						end
						if (s.ir[0] & ~s.ir[13]) begin
							n.gie = 1'b1;
						end
					end
					`CIDEC_OP_NO_OPERATION: n.pc = s.pc + 15'h0001; // RQ20 RQ21
					`CIDEC_OP_RESET: begin
						n.rst = 1'b1; // RQ20
						n.pc = 15'h0000;
						n.sp = 4'h0;
					end
					`CIDEC_OP_WDT: begin
						n.wdt = 1'b1; // RQ20
						n.timeout = 1'b1;
						n.pwrdn = 1'b1;
					end
					`CIDEC_OP_SLEEP: begin
						n.stby = 1'b1; // RQ4
						n.timeout = 1'b1; // RQ4
						n.pwrdn = 1'b0; // RQ4
					end
					`CIDEC_OP_OPTION: n.option = s.w; // RQ5
					`CIDEC_OP_PORT_DIRECTION_LOAD: n.dir[s.ir[2:0]] = s.w; // RQ6
					`CIDEC_OP_PADD: n.pptr[ptr_n] = ptr_ofs; // RQ7 RQ8
					`CIDEC_OP_LDMM: begin
						n.w = s.mem[acc_addr[6:0]]; // RQ10
						n.z = (s.mem[acc_addr[6:0]] == 8'h00); // RQ10
						n.pptr[ptr_n] = ptr_mod; // RQ10 RQ9
						hi = acc_addr[15]; // RQ15
					end
					`CIDEC_OP_LDK: begin
						n.w = s.mem[ptr_ofs[6:0]]; // RQ11
						n.z = (s.mem[ptr_ofs[6:0]] == 8'h00); // RQ11
						hi = ptr_ofs[15]; // RQ15
					end
					`CIDEC_OP_STMM: begin
						// program space is not writable through a pointer
						if (!acc_addr[15]) begin
							n.mem[acc_addr[6:0]] = s.w; // RQ12
						end
						n.pptr[ptr_n] = ptr_mod; // RQ12
						hi = acc_addr[15]; // RQ15
					end
					`CIDEC_OP_STK: begin
						if (!ptr_ofs[15]) begin
							n.mem[ptr_ofs[6:0]] = s.w; // RQ13
						end
						hi = ptr_ofs[15]; // RQ15
					end
					`CIDEC_OP_AND_LITERAL_WORKING, `CIDEC_OP_ADD_LITERAL_WORKING: begin
						n.w = alu_res; // RQ16 RQ17
						n.z = alu_z; // RQ16 RQ17
						if (s.ir[9]) begin
							n.c = alu_c; // RQ17
							n.dcy = alu_dc; // RQ17
						end
					end
					`CIDEC_OP_AND_WORKING_FILE, `CIDEC_OP_ADD_WORKING_FILE: begin
						hi = ind & s.pptr[s.ir[0]][15]; // RQ15
						if (!s.ir[7]) begin
							n.w = alu_res; // RQ18 RQ19
						end else if (!hi) begin
							n.mem[faddr] = alu_res; // RQ18 RQ19
						end
						n.z = alu_z; // RQ18 RQ19
						if (s.ir[9]) begin
							n.c = alu_c; // RQ19
							n.dcy = alu_dc; // RQ19
						end
					end
					default: n.ill = 1'b1;
				endcase
				if (jump) begin
					n.st = CIDEC_NOPC; // RQ14
					n.cyc = `CIDEC_CYC_TWO;
				end else if (hi) begin
					n.st = CIDEC_STALL; // RQ15
					n.cyc = `CIDEC_CYC_TWO;
				end else begin
					n.st = CIDEC_IDLE; // RQ21
					n.cyc = `CIDEC_CYC_ONE;
				end
			end
			CIDEC_NOPC, CIDEC_STALL: n.st = CIDEC_IDLE; // RQ14 RQ15
			default: n.st = n.st;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s <= '0;
			s.option <= `CIDEC_OPTION_RST;
			s.dir <= {8{`CIDEC_DIR_RST}};
			s.timeout <= 1'b1;
			s.pwrdn <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign standby = s.stby;
	assign watchdog_kick = s.wdt;
	assign soft_reset = s.rst;
	assign option_cfg = s.option;
	assign port_dir = s.dir;

	// ****************************************
	// checks
	// ****************************************
	default clocking cidec_cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	wbranch_two_cycle_a: assert property (s.st == CIDEC_EXEC && s.ir == `CIDEC_OP_BRANCH_BY_WORKING |=> // RQ1
		s.st == CIDEC_NOPC && s.pc == 15'($past(s.pc) + 15'h0001 + {7'h00, $past(s.w)}) && s.z == $past(s.z)
		##1 s.st == CIDEC_IDLE) else $error("working branch timing or target wrong");
	wcall_push_a: assert property (s.st == CIDEC_EXEC && s.ir == `CIDEC_OP_CALL_BY_WORKING |=> // RQ2
		s.sp == 4'($past(s.sp) + 4'h1) && s.pc == {$past(s.pc[14:8]), $past(s.w)} && s.st == CIDEC_NOPC)
		else $error("call by working wrong");
	ret_literal_a: assert property (s.st == CIDEC_EXEC && s.ir[13:8] == 6'b11_0100 |=> // RQ3
		s.w == $past(s.ir[7:0]) && s.st == CIDEC_NOPC ##1 s.st == CIDEC_IDLE)
		else $error("return with literal wrong");
	sleep_flags_a: assert property (s.st == CIDEC_EXEC && s.ir == `CIDEC_OP_SLEEP |=> // RQ4
		standby && s.timeout && !s.pwrdn && s.st == CIDEC_IDLE) else $error("standby entry wrong");
	option_load_a: assert property (s.st == CIDEC_EXEC && s.ir == `CIDEC_OP_OPTION |=> // RQ5
		option_cfg == $past(s.w) && $stable(s.z) && $stable(s.c) && s.st == CIDEC_IDLE)
		else $error("option load wrong");
	ptr_add_a: assert property (s.st == CIDEC_EXEC && s.ir[13:7] == 7'b11_0001_0 |=> // RQ7
		s.pptr[$past(s.ir[6])] == 16'($past(s.pptr[s.ir[6]]) + {{10{$past(s.ir[5])}}, $past(s.ir[5:0])})
		&& s.st == CIDEC_IDLE) else $error("pointer add wrong");
	hi_stall_a: assert property (s.st == CIDEC_EXEC && hi && !jump |=> // RQ15
		s.st == CIDEC_STALL ##1 s.st == CIDEC_IDLE) else $error("high pointer stall wrong");
	literal_and_a: assert property (s.st == CIDEC_EXEC && s.ir[13:8] == 6'b11_1001 |=> // RQ16
		s.w == ($past(s.w) & $past(s.ir[7:0])) && s.z == (s.w == 8'h00) && $stable(s.c))
		else $error("literal and wrong");
	noop_single_a: assert property (s.st == CIDEC_EXEC && s.ir == `CIDEC_OP_NO_OPERATION |=> // RQ21
		s.st == CIDEC_IDLE && s.cyc == `CIDEC_CYC_ONE) else $error("no-operation not single cycle");
endmodule : cidec_core
`default_nettype wire

//--- rtl/cidec_unused_placeholder_removed.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- tb/cidec_prog_rom.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// program memory slots holding control ops
// ****************************************
module cidec_prog_rom (
	input wire logic [2:0] idx, // fetch slot
	output logic [13:0] op // opcode word
);
	always_comb begin
		case (idx)
			3'h0: op = 14'h000a;
			3'h1: op = 14'h0008;
			3'h2: op = 14'h2010;
			3'h3: op = 14'h3455;
			3'h4: op = 14'h0009;
			3'h5: op = 14'h000b;
			3'h6: op = 14'h2810;
			default: op = 14'h3205;
		endcase
	end
endmodule : cidec_prog_rom
`default_nettype wire

//--- tb/cidec_core_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cidec_defs.svh"
module cidec_core_tb_top;
	logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, err;
	logic standby, watchdog_kick, soft_reset;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] option_cfg;
	logic [63:0] port_dir;
	logic [2:0] rom_idx;
	logic [13:0] rom_op;
	int n_errors, n_checks, n_cyc, n_kick, n_rst;

	cidec_core i_cidec_core (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .standby(standby), .watchdog_kick(watchdog_kick),
		.soft_reset(soft_reset), .option_cfg(option_cfg), .port_dir(port_dir));
	cidec_prog_rom i_cidec_prog_rom (.idx(rom_idx), .op(rom_op));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		n_cyc++;
		if (srst === 1'b0 && watchdog_kick === 1'b1) n_kick++;
		if (srst === 1'b0 && soft_reset === 1'b1) n_rst++;
		if (n_cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	// ****************************************
	// bus tasks and compare
	// ****************************************
	task automatic report_and_stop();
		if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdr(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rdr

	// leaves the status word in rd once busy has cleared
	task automatic exec(input logic [13:0] op);
		wr(`CIDEC_A_INSTR, {18'h0, op});
		rdr(`CIDEC_A_STATUS);
		for (int i = 0; i < 8 && rd[8] !== 1'b0; i++) rdr(`CIDEC_A_STATUS);
	endtask : exec

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		rom_idx = 3'h0;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		rdr(`CIDEC_A_OPTION); chk(rd, 32'hff);
		rdr(`CIDEC_A_STATUS); chk(rd & 32'h1ff, 32'h18);
		chk({24'h0, port_dir[7:0]}, 32'hff);
		wr(`CIDEC_A_WORK, 32'h0f);
		exec(14'h3ef1); chk(rd & 32'h607, 32'h207);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h0);
		wr(`CIDEC_A_WORK, 32'h3c);
		exec(14'h39c3); chk(rd & 32'h607, 32'h207);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h0);
		wr(`CIDEC_A_WORK, 32'h5a);
		exec(14'h0062); chk(rd & 32'h607, 32'h207);
		chk({24'h0, option_cfg}, 32'h5a);
		wr(`CIDEC_A_WORK, 32'ha5);
		exec(14'h0065); chk({24'h0, port_dir[47:40]}, 32'ha5);
		wr(`CIDEC_A_PTR0, 32'h0);
		exec(14'h313f); chk(rd & 32'h607, 32'h207);
		rdr(`CIDEC_A_PTR0); chk(rd, 32'hffff);
		wr(`CIDEC_A_PTR1, 32'hfff0);
		exec(14'h315f);
		rdr(`CIDEC_A_PTR1); chk(rd, 32'h000f);
		wr(`CIDEC_A_PTR0, 32'h10);
		wr(`CIDEC_A_WORK, 32'h77);
		exec(14'h001a); chk(rd & 32'h607, 32'h207);
		rdr(12'h240); chk(rd, 32'h77);
		rdr(`CIDEC_A_PTR0); chk(rd, 32'h11);
		wr(`CIDEC_A_WORK, 32'h0);
		exec(14'h0011); chk(rd & 32'h607, 32'h203);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h77);
		rdr(`CIDEC_A_PTR0); chk(rd, 32'h10);
		// post-decrement, then pre-increment back
		wr(`CIDEC_A_WORK, 32'h0);
		exec(14'h0013);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h77);
		rdr(`CIDEC_A_PTR0); chk(rd, 32'h0f);
		wr(`CIDEC_A_WORK, 32'h0);
		exec(14'h0010);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h77);
		rdr(`CIDEC_A_PTR0); chk(rd, 32'h10);
		wr(`CIDEC_A_PTR1, 32'h20);
		wr(`CIDEC_A_WORK, 32'h3c);
		exec(14'h3fc2);
		rdr(12'h288); chk(rd, 32'h3c);
		exec(14'h3f70);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h77);
		exec(14'h3f42); chk(rd & 32'h607, 32'h203);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h3c);
		rdr(`CIDEC_A_PTR1); chk(rd, 32'h20);
		wr(`CIDEC_A_PTR0, 32'h8010);
		exec(14'h3f00); chk(rd & 32'h600, 32'h400);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h77);
		wr(`CIDEC_A_WORK, 32'h0f);
		exec(14'h0590);
		rdr(12'h240); chk(rd, 32'h07);
		exec(14'h0710); chk(rd & 32'h607, 32'h202);
		rdr(`CIDEC_A_WORK); chk(rd, 32'h16);
		wr(`CIDEC_A_PC, 32'h0);
		for (int i = 0; i < 8; i++) begin
			rom_idx <= i[2:0];
			@(posedge ref_clk);
			exec(rom_op); chk(rd & 32'h602, 32'h402);
		end
		rdr(`CIDEC_A_WORK); chk(rd, 32'h55);
		rdr(`CIDEC_A_PC); chk(rd, 32'h16);
		exec(14'h0000); chk(rd & 32'h607, 32'h202);
		exec(14'h0064); chk(rd & 32'h618, 32'h218);
		chk(n_kick, 1);
		exec(14'h0001); chk(n_rst, 1);
		rdr(`CIDEC_A_PC); chk(rd, 32'h0);
		exec(14'h0063); chk(rd & 32'h698, 32'h290);
		chk({31'h0, standby}, 32'h1);
		wr(`CIDEC_A_INSTR, 32'h0064); chk({31'h0, err}, 32'h1);
		wr(`CIDEC_A_STATUS, 32'h0);
		// the write landed on the edge wr returned on; look one edge later once it has settled
		@(posedge ref_clk);
		chk({31'h0, standby}, 32'h0);
		rdr(12'h100); chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		report_and_stop();
	end
endmodule : cidec_core_tb_top
`default_nettype wire
